// ### cam_defs.vh
// constants of the cpu datapath: opcodes, states, flag bits, memory map
`ifndef CAM_DEFS_VH
`define CAM_DEFS_VH
`define CAM_OP_NOP    6'h00
`define CAM_OP_ADD    6'h01
`define CAM_OP_ADC    6'h02
`define CAM_OP_SUB    6'h03
`define CAM_OP_SBC    6'h04
`define CAM_OP_AND    6'h05
`define CAM_OP_OR     6'h06
`define CAM_OP_EOR    6'h07
`define CAM_OP_MOV    6'h08
`define CAM_OP_LDIMM  6'h09
`define CAM_OP_SUBI   6'h0A
`define CAM_OP_SBCI   6'h0B
`define CAM_OP_ANDI   6'h0C
`define CAM_OP_ORI    6'h0D
`define CAM_OP_COM    6'h0E
`define CAM_OP_NEG    6'h0F
`define CAM_OP_INC    6'h10
`define CAM_OP_DEC    6'h11
`define CAM_OP_LSR    6'h12
`define CAM_OP_ROR    6'h13
`define CAM_OP_ASR    6'h14
`define CAM_OP_SWAP   6'h15
`define CAM_OP_ADDW   6'h16
`define CAM_OP_SUBW   6'h17
`define CAM_OP_MUL    6'h18
`define CAM_OP_MULS   6'h19
`define CAM_OP_MULSU  6'h1A
`define CAM_OP_FMUL   6'h1B
`define CAM_OP_FMULS  6'h1C
`define CAM_OP_FMULSU 6'h1D
`define CAM_OP_LOAD   6'h1E
`define CAM_OP_STORE  6'h1F
`define CAM_OP_PMRD   6'h20
`define CAM_OP_PIN    6'h21
`define CAM_OP_POUT   6'h22
`define CAM_OP_IOSET  6'h23
`define CAM_OP_IOCLR  6'h24
`define CAM_OP_IOSKS  6'h25
`define CAM_OP_IOSKC  6'h26
`define CAM_OP_JUMP   6'h27
`define CAM_OP_CMP    6'h28
`define CAM_OP_CMPI   6'h29
`define CAM_ST_RUN    2'h0
`define CAM_ST_MUL    2'h1
`define CAM_ST_LOAD   2'h2
`define CAM_ST_PMEM   2'h3
`define CAM_FL_C      0
`define CAM_FL_Z      1
`define CAM_FL_N      2
`define CAM_FL_V      3
`define CAM_FL_S      4
`define CAM_FL_H      5
`define CAM_FLAG_RST  8'h00
`define CAM_PC_RST    16'h0000
`define CAM_EXT_BASE  16'h0040
`define CAM_NVM_BASE  16'h1000
`define CAM_MEM_BASE  16'h1800
`define CAM_FLASH_BIT 15
`define CAM_RG_IO     3'h0
`define CAM_RG_EXT    3'h1
`define CAM_RG_NVM    3'h2
`define CAM_RG_MEM    3'h3
`define CAM_RG_FLASH  3'h4
`define CAM_PTR_BASE  5'h1A
`define CAM_PTR_Z     2'h2
`define CAM_PTR_DIR   2'h3
`define CAM_PM_PLAIN  2'h0
`define CAM_PM_INC    2'h1
`define CAM_PM_DEC    2'h2
`define CAM_PM_DISP   2'h3
`endif

// ### cam_core.v
// cpu datapath: prefetch, register file, alu, multiplier, data space decode
`include "cam_defs.vh"
`default_nettype none
module cam_core #(
    parameter RF_DEPTH = 32                 // working registers
) (
    input  wire        ref_clk_i,       // cpu clock
    input  wire        reset_n_i,       // async reset, active low
    output wire [15:0] prog_addr_o,     // program word address
    input  wire [15:0] prog_data_i,     // word at prog_addr_o
    output wire [15:0] instr_o,         // instruction now executing
    output wire        instr_valid_o,   // instr_o may be executed
    output wire        busy_o,          // multi-cycle op in progress
    input  wire        exec_i,          // decoded op valid
    input  wire [5:0]  op_i,            // decoded operation
    input  wire [4:0]  rd_i,            // destination register
    input  wire [4:0]  rr_i,            // source register
    input  wire [7:0]  imm_i,           // immediate, displacement, bit
    input  wire [15:0] addr_i,          // direct, i/o or jump address
    input  wire [1:0]  ptr_sel_i,       // 0..2 pointer pair, 3 direct
    input  wire [1:0]  ptr_mode_i,      // plain, post-inc, pre-dec, disp
    input  wire        wide_i,          // access to a 16-bit register
    input  wire [7:0]  io_rdata_i,      // i/o location addr_i[5:0]
    output wire [15:0] data_addr_o,     // data space byte address
    output wire [7:0]  data_wdata_o,    // write byte
    output wire [7:0]  data_wlow_o,     // low byte of 16-bit write
    output wire        data_we_o,       // byte write strobe
    output wire        data_we16_o,     // 16-bit commit strobe
    output wire        data_re_o,       // read strobe
    output wire [2:0]  data_rgn_o,      // decoded region
    input  wire [15:0] data_rdata_i,    // read data, in the cycle data_re_o is high
    output wire [7:0]  flag_o           // flag register
);
    reg        rst_s1_reg;
    reg        rst_s2_reg;
    reg [7:0]  rf_reg [0:RF_DEPTH-1];
    reg [1:0]  state_reg;
    reg [15:0] pc_reg;
    reg [15:0] paddr_reg;
    reg [15:0] instr_reg;
    reg        ivalid_reg;
    reg        busy_reg;
    reg [7:0]  flag_reg;
    reg [15:0] daddr_reg;
    reg [7:0]  dwdata_reg;
    reg [7:0]  dwlow_reg;
    reg        dwe_reg;
    reg        dwe16_reg;
    reg        dre_reg;
    reg [2:0]  drgn_reg;
    reg [7:0]  temp_reg;
    reg [7:0]  mul_a_reg;
    reg [7:0]  mul_b_reg;
    reg [5:0]  mul_op_reg;
    reg [4:0]  ld_rd_reg;
    reg        ld_wide_reg;
    reg        bsel_reg;
    integer    i;

    // reset release through two flops
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    wire rst_n = rst_s2_reg;

    // pointer pair select and effective address
    wire        is_pm   = (op_i == `CAM_OP_PMRD);
    wire [1:0]  psel    = is_pm ? `CAM_PTR_Z : ptr_sel_i;
    wire [4:0]  ptr_lo  = `CAM_PTR_BASE + {2'b00, psel, 1'b0};
    wire [4:0]  ptr_hi  = ptr_lo + 5'h01;
    wire [15:0] ptr_val = {rf_reg[ptr_hi], rf_reg[ptr_lo]};
    wire [15:0] ptr_inc = ptr_val + 16'h0001;
    wire [15:0] ptr_dec = ptr_val - 16'h0001;
    wire        ptr_dir = (psel == `CAM_PTR_DIR);
    wire        ptr_upd = !ptr_dir && (ptr_mode_i == `CAM_PM_INC || ptr_mode_i == `CAM_PM_DEC);
    wire [15:0] ptr_new = (ptr_mode_i == `CAM_PM_INC) ? ptr_inc : ptr_dec;
    reg  [15:0] eff;
    always @* begin
        case (ptr_mode_i)
            `CAM_PM_DEC:  eff = ptr_dec;
            `CAM_PM_DISP: eff = ptr_val + {10'h000, imm_i[5:0]};
            default:      eff = ptr_val;
        endcase
        if (ptr_dir)
            eff = addr_i;                    // full 16-bit direct reach
    end

    // data space region decode
    function [2:0] region;
        input [15:0] a;
        begin
            if (a[`CAM_FLASH_BIT])
                region = `CAM_RG_FLASH;
            else if (a < `CAM_EXT_BASE)
                region = `CAM_RG_IO;
            else if (a < `CAM_NVM_BASE)
                region = `CAM_RG_EXT;
            else if (a < `CAM_MEM_BASE)
                region = `CAM_RG_NVM;
            else
                region = `CAM_RG_MEM;
        end
    endfunction
    wire [2:0] eff_rgn = region(eff);

    // alu operands
    wire       use_imm = (op_i == `CAM_OP_LDIMM) || (op_i == `CAM_OP_SUBI) ||
                         (op_i == `CAM_OP_SBCI) || (op_i == `CAM_OP_ANDI) ||
                         (op_i == `CAM_OP_ORI) || (op_i == `CAM_OP_CMPI);
    wire [7:0] a_op = rf_reg[rd_i];
    wire [7:0] b_op = use_imm ? imm_i : rf_reg[rr_i];
    wire       cin  = ((op_i == `CAM_OP_ADC) || (op_i == `CAM_OP_SBC) ||
                       (op_i == `CAM_OP_SBCI)) & flag_reg[`CAM_FL_C];
    wire [8:0] sum9 = {1'b0, a_op} + {1'b0, b_op} + {8'h00, cin};
    wire [8:0] dif9 = {1'b0, a_op} - {1'b0, b_op} - {8'h00, cin};
    wire [4:0] rd1  = rd_i + 5'h01;
    wire [15:0] p16 = {rf_reg[rd1], a_op};
    wire [15:0] w6  = {10'h000, imm_i[5:0]};

    // alu result and flags
    reg [7:0]  r;
    reg [15:0] r16;
    reg        fc, fh, fv, fn, fz, upd, wr, w16, zkeep, vsh;
    reg [7:0]  flg_n;
    always @* begin
        r = a_op;
        r16 = p16;
        fc = flag_reg[`CAM_FL_C];
        fh = flag_reg[`CAM_FL_H];
        fv = 1'b0;
        upd = 1'b0;
        wr = 1'b0;
        w16 = 1'b0;
        zkeep = 1'b0;
        vsh = 1'b0;
        case (op_i)
            `CAM_OP_ADD, `CAM_OP_ADC: begin
                r = sum9[7:0];
                fc = sum9[8];
                fh = (a_op[3] & b_op[3]) | (b_op[3] & ~r[3]) | (~r[3] & a_op[3]);
                fv = (a_op[7] & b_op[7] & ~r[7]) | (~a_op[7] & ~b_op[7] & r[7]);
                upd = 1'b1;
                wr = 1'b1;
            end
            `CAM_OP_SUB, `CAM_OP_SBC, `CAM_OP_SUBI, `CAM_OP_SBCI,
            `CAM_OP_CMP, `CAM_OP_CMPI: begin
                r = dif9[7:0];
                fc = (~a_op[7] & b_op[7]) | (b_op[7] & r[7]) | (r[7] & ~a_op[7]);
                fh = (~a_op[3] & b_op[3]) | (b_op[3] & r[3]) | (r[3] & ~a_op[3]);
                fv = (a_op[7] & ~b_op[7] & ~r[7]) | (~a_op[7] & b_op[7] & r[7]);
                zkeep = (op_i == `CAM_OP_SBC) || (op_i == `CAM_OP_SBCI);
                upd = 1'b1;
                wr = (op_i != `CAM_OP_CMP) && (op_i != `CAM_OP_CMPI);
            end
            `CAM_OP_AND, `CAM_OP_ANDI: begin
                r = a_op & b_op;
                upd = 1'b1;
                wr = 1'b1;
            end
            `CAM_OP_OR, `CAM_OP_ORI: begin
                r = a_op | b_op;
                upd = 1'b1;
                wr = 1'b1;
            end
            `CAM_OP_EOR: begin
                r = a_op ^ b_op;
                upd = 1'b1;
                wr = 1'b1;
            end
            `CAM_OP_MOV, `CAM_OP_LDIMM: begin
                r = b_op;
                wr = 1'b1;
            end
            `CAM_OP_COM: begin
                r = ~a_op;
                fc = 1'b1;
                upd = 1'b1;
                wr = 1'b1;
            end
            `CAM_OP_NEG: begin
                r = 8'h00 - a_op;
                fc = (r != 8'h00);
                fv = (r == 8'h80);
                fh = r[3] | a_op[3];
                upd = 1'b1;
                wr = 1'b1;
            end
            `CAM_OP_INC, `CAM_OP_DEC: begin
                r = (op_i == `CAM_OP_INC) ? a_op + 8'h01 : a_op - 8'h01;
                fv = (op_i == `CAM_OP_INC) ? (r == 8'h80) : (r == 8'h7F);
                upd = 1'b1;
                wr = 1'b1;
            end
            `CAM_OP_LSR, `CAM_OP_ROR, `CAM_OP_ASR: begin
                r = {(op_i == `CAM_OP_ROR) ? flag_reg[`CAM_FL_C] :
                     (op_i == `CAM_OP_ASR) & a_op[7], a_op[7:1]};
                fc = a_op[0];
                vsh = 1'b1;
                upd = 1'b1;
                wr = 1'b1;
            end
            `CAM_OP_SWAP: begin
                r = {a_op[3:0], a_op[7:4]};
                wr = 1'b1;
            end
            `CAM_OP_ADDW, `CAM_OP_SUBW: begin
                r16 = (op_i == `CAM_OP_ADDW) ? p16 + w6 : p16 - w6;
                fc = (op_i == `CAM_OP_ADDW) ? (~r16[15] & p16[15]) : (r16[15] & ~p16[15]);
                fv = (op_i == `CAM_OP_ADDW) ? (~p16[15] & r16[15]) : (p16[15] & ~r16[15]);
                w16 = 1'b1;
                upd = 1'b1;
            end
            default: begin
                r = a_op;
            end
        endcase
        fn = w16 ? r16[15] : r[7];
        fz = w16 ? (r16 == 16'h0000) : ((r == 8'h00) & (~zkeep | flag_reg[`CAM_FL_Z]));
        if (vsh)
            fv = fn ^ fc;
        flg_n = flag_reg;
        flg_n[`CAM_FL_C] = fc;
        flg_n[`CAM_FL_Z] = fz;
        flg_n[`CAM_FL_N] = fn;
        flg_n[`CAM_FL_V] = fv;
        flg_n[`CAM_FL_S] = fn ^ fv;
        flg_n[`CAM_FL_H] = fh;
    end

    // multiplier: sign-extend per form, fractional shifts left one
    wire        sa    = (mul_op_reg == `CAM_OP_MULS) || (mul_op_reg == `CAM_OP_MULSU) ||
                        (mul_op_reg == `CAM_OP_FMULS) || (mul_op_reg == `CAM_OP_FMULSU);
    wire        sb    = (mul_op_reg == `CAM_OP_MULS) || (mul_op_reg == `CAM_OP_FMULS);
    wire        frac  = (mul_op_reg == `CAM_OP_FMUL) || (mul_op_reg == `CAM_OP_FMULS) ||
                        (mul_op_reg == `CAM_OP_FMULSU);
    wire [15:0] ma    = {{8{sa & mul_a_reg[7]}}, mul_a_reg};
    wire [15:0] mb    = {{8{sb & mul_b_reg[7]}}, mul_b_reg};
    wire [31:0] mfull = ma * mb;
    wire [15:0] prod  = mfull[15:0];
    wire [15:0] mres  = frac ? {prod[14:0], 1'b0} : prod;
    wire        is_mul = (op_i >= `CAM_OP_MUL) && (op_i <= `CAM_OP_FMULSU);
    wire        io_bit = io_rdata_i[imm_i[2:0]];
    wire [15:0] io_a6  = {10'h000, addr_i[5:0]};
    wire [15:0] io_a5  = {11'h000, addr_i[4:0]};
    wire [15:0] pc_inc = pc_reg + 16'h0001;

    // fetch, execute, write back, memory sequencing
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < RF_DEPTH; i = i + 1)
                rf_reg[i] <= 8'h00;
            state_reg <= `CAM_ST_RUN;
            pc_reg <= `CAM_PC_RST;
            paddr_reg <= `CAM_PC_RST;
            instr_reg <= 16'h0000;
            ivalid_reg <= 1'b0;
            busy_reg <= 1'b0;
            flag_reg <= `CAM_FLAG_RST;
            daddr_reg <= 16'h0000;
            dwdata_reg <= 8'h00;
            dwlow_reg <= 8'h00;
            dwe_reg <= 1'b0;
            dwe16_reg <= 1'b0;
            dre_reg <= 1'b0;
            drgn_reg <= `CAM_RG_IO;
            temp_reg <= 8'h00;
            mul_a_reg <= 8'h00;
            mul_b_reg <= 8'h00;
            mul_op_reg <= `CAM_OP_NOP;
            ld_rd_reg <= 5'h00;
            ld_wide_reg <= 1'b0;
            bsel_reg <= 1'b0;
        end else begin
            dwe_reg <= 1'b0;
            dwe16_reg <= 1'b0;
            dre_reg <= 1'b0;
            case (state_reg)
                `CAM_ST_RUN: begin
                    instr_reg <= prog_data_i;
                    ivalid_reg <= 1'b1;
                    pc_reg <= pc_inc;
                    paddr_reg <= pc_inc;
                    if (exec_i) begin
                        if (wr)
                            rf_reg[rd_i] <= r;
                        if (w16) begin
                            rf_reg[rd_i] <= r16[7:0];
                            rf_reg[rd1] <= r16[15:8];
                        end
                        if (upd)
                            flag_reg <= flg_n;
                        if (is_mul) begin
                            mul_a_reg <= a_op;
                            mul_b_reg <= rf_reg[rr_i];
                            mul_op_reg <= op_i;
                            state_reg <= `CAM_ST_MUL;
                            busy_reg <= 1'b1;
                        end
                        if ((op_i == `CAM_OP_LOAD || op_i == `CAM_OP_STORE || is_pm) && ptr_upd) begin
                            rf_reg[ptr_lo] <= ptr_new[7:0];
                            rf_reg[ptr_hi] <= ptr_new[15:8];
                        end
                        ld_rd_reg <= rd_i;
                        ld_wide_reg <= wide_i;
                        case (op_i)
                            `CAM_OP_LOAD: begin
                                if (eff_rgn == `CAM_RG_FLASH) begin
                                    paddr_reg <= {2'b00, eff[14:1]};
                                    bsel_reg <= eff[0];
                                    state_reg <= `CAM_ST_PMEM;
                                    busy_reg <= 1'b1;
                                end else if (wide_i && eff[0]) begin
                                    rf_reg[rd_i] <= temp_reg;
                                end else begin
                                    daddr_reg <= eff;
                                    drgn_reg <= eff_rgn;
                                    dre_reg <= 1'b1;
                                    state_reg <= `CAM_ST_LOAD;
                                    busy_reg <= 1'b1;
                                end
                            end
                            `CAM_OP_STORE: begin
                                if (eff_rgn != `CAM_RG_FLASH) begin
                                    if (wide_i && !eff[0]) begin
                                        temp_reg <= a_op;
                                    end else begin
                                        daddr_reg <= eff;
                                        drgn_reg <= eff_rgn;
                                        dwdata_reg <= a_op;
                                        dwlow_reg <= temp_reg;
                                        dwe_reg <= !wide_i;
                                        dwe16_reg <= wide_i;
                                    end
                                end
                            end
                            `CAM_OP_PMRD: begin
                                paddr_reg <= {1'b0, eff[15:1]};
                                bsel_reg <= eff[0];
                                state_reg <= `CAM_ST_PMEM;
                                busy_reg <= 1'b1;
                            end
                            `CAM_OP_PIN:
                                rf_reg[rd_i] <= io_rdata_i;
                            `CAM_OP_POUT, `CAM_OP_IOSET, `CAM_OP_IOCLR: begin
                                daddr_reg <= (op_i == `CAM_OP_POUT) ? io_a6 : io_a5;
                                drgn_reg <= `CAM_RG_IO;
                                dwdata_reg <= (op_i == `CAM_OP_POUT) ? a_op :
                                              (op_i == `CAM_OP_IOSET) ?
                                              (io_rdata_i | (8'h01 << imm_i[2:0])) :
                                              (io_rdata_i & ~(8'h01 << imm_i[2:0]));
                                dwe_reg <= 1'b1;
                            end
                            `CAM_OP_IOSKS, `CAM_OP_IOSKC: begin
                                if (io_bit == (op_i == `CAM_OP_IOSKS))
                                    ivalid_reg <= 1'b0;
                            end
                            `CAM_OP_JUMP: begin
                                pc_reg <= addr_i;
                                paddr_reg <= addr_i;
                                ivalid_reg <= 1'b0;
                            end
                            default: begin
                                ld_wide_reg <= wide_i;
                            end
                        endcase
                    end
                end
                `CAM_ST_MUL: begin
                    rf_reg[0] <= mres[7:0];
                    rf_reg[1] <= mres[15:8];
                    flag_reg[`CAM_FL_C] <= prod[15];
                    flag_reg[`CAM_FL_Z] <= (mres == 16'h0000);
                    state_reg <= `CAM_ST_RUN;
                    busy_reg <= 1'b0;
                end
                `CAM_ST_LOAD: begin
                    rf_reg[ld_rd_reg] <= data_rdata_i[7:0];
                    if (ld_wide_reg)
                        temp_reg <= data_rdata_i[15:8];
                    state_reg <= `CAM_ST_RUN;
                    busy_reg <= 1'b0;
                end
                default: begin
                    rf_reg[ld_rd_reg] <= bsel_reg ? prog_data_i[15:8] : prog_data_i[7:0];
                    paddr_reg <= pc_reg;
                    state_reg <= `CAM_ST_RUN;
                    busy_reg <= 1'b0;
                end
            endcase
        end
    end

    // outputs straight from flops
    assign prog_addr_o   = paddr_reg;
    assign instr_o       = instr_reg;
    assign instr_valid_o = ivalid_reg;
    assign busy_o        = busy_reg;
    assign data_addr_o   = daddr_reg;
    assign data_wdata_o  = dwdata_reg;
    assign data_wlow_o   = dwlow_reg;
    assign data_we_o     = dwe_reg;
    assign data_we16_o   = dwe16_reg;
    assign data_re_o     = dre_reg;
    assign data_rgn_o    = drgn_reg;
    assign flag_o        = flag_reg;
endmodule // cam_core
`default_nettype wire

// ### cam_core_asserts.sv
// port checks on the cpu datapath
`include "cam_defs.vh"
`default_nettype none
module cam_core_asserts (
    input wire logic        ref_clk_i,     // cpu clock
    input wire logic        reset_n_i,     // reset, low
    input wire logic [15:0] prog_addr_o,   // word address
    input wire logic        instr_valid_o, // fetch valid
    input wire logic        busy_o,        // two-cycle op
    input wire logic        exec_i,        // op taken
    input wire logic [5:0]  op_i,          // operation
    input wire logic [15:0] addr_i,        // direct address
    input wire logic [1:0]  ptr_sel_i,     // pointer select
    input wire logic        wide_i,        // 16-bit access
    input wire logic [15:0] data_addr_o,   // byte address
    input wire logic        data_we_o,     // write strobe
    input wire logic        data_re_o,     // read strobe
    input wire logic [2:0]  data_rgn_o     // region
);
    // region expected from the address alone
    wire logic [2:0] rgn_exp = data_addr_o < 16'h0040 ? 3'h0 : data_addr_o < 16'h1000 ? 3'h1 :
        data_addr_o < 16'h1800 ? 3'h2 : data_addr_o[15] ? 3'h4 : 3'h3;
    wire logic direct = exec_i && !busy_o && ptr_sel_i == 2'h3 && !wide_i && !addr_i[15];
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_reset_addr_zero: assert property (disable iff (1'b0) !reset_n_i |-> prog_addr_o == 16'h0000)
        else $error("address not zero in reset");
    a_fetch_step: assert property (instr_valid_o && !busy_o && !exec_i |=> prog_addr_o == $past(prog_addr_o) + 16'h0001)
        else $error("fetch did not step");
    a_busy_single: assert property (busy_o |=> !busy_o)
        else $error("busy too long");
    a_mul_two: assert property (exec_i && !busy_o && op_i >= `CAM_OP_MUL && op_i <= `CAM_OP_FMULSU |=> busy_o ##1 !busy_o)
        else $error("multiply not two cycles");
    a_store_strobe: assert property (direct && op_i == `CAM_OP_STORE |=> data_we_o && data_addr_o == $past(addr_i))
        else $error("store strobe missing");
    a_load_pulse: assert property (direct && op_i == `CAM_OP_LOAD |=> data_re_o && busy_o ##1 !data_re_o)
        else $error("load pulse wrong");
    a_region_map: assert property (data_we_o || data_re_o |-> data_rgn_o == rgn_exp)
        else $error("region decode wrong");
    a_flash_no_store: assert property (data_we_o |-> !data_addr_o[15])
        else $error("write into flash");
endmodule // cam_core_asserts
bind cam_core cam_core_asserts i_cam_core_asserts (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .prog_addr_o(prog_addr_o), .instr_valid_o(instr_valid_o), .busy_o(busy_o), .exec_i(exec_i),
    .op_i(op_i), .addr_i(addr_i), .ptr_sel_i(ptr_sel_i), .wide_i(wide_i),
    .data_addr_o(data_addr_o), .data_we_o(data_we_o), .data_re_o(data_re_o),
    .data_rgn_o(data_rgn_o));
`default_nettype wire

// ### cam_mem_model.sv
// program and data memory on the far side
`default_nettype none
module cam_mem_model (
    input  wire logic        clk_i,        // cpu clock
    input  wire logic [15:0] prog_addr_i,  // word address
    output logic      [15:0] prog_data_o,  // word
    input  wire logic [15:0] data_addr_i,  // byte address
    input  wire logic        data_re_i,    // read strobe
    output logic      [15:0] data_rdata_o  // read data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] junk_reg = 16'h5A5A;
    // flash word n holds n xor a marker, word zero first
    assign prog_data_o = prog_addr_i ^ 16'hA500;
    // answer while the strobe stands, else a changing pattern
    always @(posedge clk_i) junk_reg <= ~junk_reg;
    assign data_rdata_o = data_re_i ? {data_addr_i[7:0], ~data_addr_i[7:0]} : junk_reg;
endmodule // cam_mem_model
`default_nettype wire

// ### cpu_alu_memory_map_bench.sv
// bench for the cpu datapath
`include "cam_defs.vh"
`default_nettype none
module cpu_alu_memory_map_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic             ref_clk_i = 1'b0;
    logic             reset_n_i = 1'b1;
    logic             exec_i = 1'b0;
    logic [5:0]       op_i = 6'h00;
    logic [4:0]       rd_i = 5'h00, rr_i = 5'h00;
    logic [7:0]       imm_i = 8'h00;
    logic [15:0]      addr_i = 16'h0000;
    logic             wide = 1'b0;
    wire logic [15:0] pa, pd, ins, da, dr;
    wire logic [7:0]  wd, fl, wl;
    wire logic [2:0]  rg;
    wire logic        iv, bz, we, re, we16;
    int               err_count = 0, cmp_count = 0, cyc = 0;
    cam_core i_cam_core (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .prog_addr_o(pa),
        .prog_data_i(pd), .instr_o(ins), .instr_valid_o(iv), .busy_o(bz), .exec_i(exec_i),
        .op_i(op_i), .rd_i(rd_i), .rr_i(rr_i), .imm_i(imm_i), .addr_i(addr_i),
        .ptr_sel_i(2'h3), .ptr_mode_i(2'h0), .wide_i(wide), .io_rdata_i(8'h00),
        .data_addr_o(da), .data_wdata_o(wd), .data_wlow_o(wl), .data_we_o(we), .data_we16_o(we16),
        .data_re_o(re), .data_rgn_o(rg), .data_rdata_i(dr), .flag_o(fl));
    cam_mem_model i_cam_mem_model (.clk_i(ref_clk_i), .prog_addr_i(pa), .prog_data_o(pd),
        .data_addr_i(da), .data_re_i(re), .data_rdata_o(dr));
    always #20 ref_clk_i = ~ref_clk_i;
    // cycle ceiling against a hang
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [5:0] op, input logic [4:0] rd, input logic [15:0] adr,
        input logic [7:0] imm);
        @(negedge ref_clk_i);
        {op_i, rd_i, rr_i, imm_i, addr_i, exec_i} = {op, rd, 5'h11, imm, adr, 1'b1};
        @(negedge ref_clk_i);
        exec_i = 1'b0;
        repeat (3) if (bz === 1'b1) @(negedge ref_clk_i);
    endtask
    // store a register, compare strobe, region, address and byte
    task automatic st(input logic [4:0] r, input logic [15:0] adr, input logic [2:0] g,
        input logic [7:0] exp);
        run(`CAM_OP_STORE, r, adr, 8'h00);
        chk({we, rg, da, wd}, {1'b1, g, adr, exp});
    endtask
    task automatic t_alu();
        run(`CAM_OP_LDIMM, 5'h10, 16'h0000, 8'h12);
        run(`CAM_OP_LDIMM, 5'h11, 16'h0000, 8'h34);
        run(`CAM_OP_ADD, 5'h10, 16'h0000, 8'h00);
        st(5'h10, 16'h0100, 3'h1, 8'h46);
        run(`CAM_OP_SUB, 5'h11, 16'h0000, 8'h00);
        chk(fl, 8'h02);
    endtask
    task automatic t_mul();
        logic [15:0] prod [6] = '{16'h01FE, 16'hFFFE, 16'hFFFE, 16'h03FC, 16'hFFFC, 16'hFFFC};
        run(`CAM_OP_LDIMM, 5'h10, 16'h0000, 8'hFF);
        run(`CAM_OP_LDIMM, 5'h11, 16'h0000, 8'h02);
        for (int k = 0; k < 6; k++) begin
            run(6'(`CAM_OP_MUL + k), 5'h10, 16'h0000, 8'h00);
            chk(fl[0], prod[k][15]);
            st(5'h00, 16'h0040, 3'h1, prod[k][7:0]);
            st(5'h01, 16'h0041, 3'h1, prod[k][15:8]);
        end
    endtask
    task automatic t_mem();
        logic [15:0] a [7] = '{16'h003F, 16'h0040, 16'h0FFF, 16'h1000, 16'h17FF, 16'h1800, 16'h7FFF};
        logic [2:0] g [7] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3};
        for (int k = 0; k < 7; k++) st(5'h10, a[k], g[k], 8'hFF);
        run(`CAM_OP_LOAD, 5'h05, 16'h1934, 8'h00);
        st(5'h05, 16'h0020, 3'h0, 8'hCB);
        run(`CAM_OP_LOAD, 5'h06, 16'h8005, 8'h00);
        st(5'h06, 16'h0021, 3'h0, 8'hA5);
        run(`CAM_OP_LDIMM, 5'h1E, 16'h0000, 8'h04);
        run(`CAM_OP_LDIMM, 5'h1F, 16'h0000, 8'h00);
        run(`CAM_OP_PMRD, 5'h07, 16'h0000, 8'h00);
        st(5'h07, 16'h0022, 3'h0, 8'h02);
        run(`CAM_OP_STORE, 5'h07, 16'h8000, 8'h00);
        chk(we, 1'b0);
        wide = 1'b1;
        run(`CAM_OP_STORE, 5'h05, 16'h0A00, 8'h00);
        chk({we, we16}, 2'b00);
        run(`CAM_OP_STORE, 5'h06, 16'h0A01, 8'h00);
        chk({we16, wl, wd, da[11:0]}, {1'b1, 8'hCB, 8'hA5, 12'hA01});
        run(`CAM_OP_LOAD, 5'h08, 16'h1934, 8'h00);
        run(`CAM_OP_LOAD, 5'h09, 16'h1935, 8'h00);
        wide = 1'b0;
        st(5'h09, 16'h0023, 3'h0, 8'h34);
        run(`CAM_OP_IOSET, 5'h00, 16'h0025, 8'h03);
        chk({we, da, wd}, {1'b1, 16'h0005, 8'h08});
        run(`CAM_OP_IOSKC, 5'h00, 16'h0001, 8'h00);
        chk(iv, 1'b0);
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // reset, then each scenario in turn
    initial begin
        #1 reset_n_i = 1'b0;
        repeat (16) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        repeat (8) if (iv !== 1'b1) @(negedge ref_clk_i);
        chk({ins, pa}, {16'hA500, 16'h0001});
        t_alu();
        t_mul();
        t_mem();
        complete_run();
    end
endmodule // cpu_alu_memory_map_bench
`default_nettype wire
